// ---- sar_conv_ctrl.sv ----
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
module sar_conv_ctrl
  import sar_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic conversion_trigger_in,
  input wire logic comp_in,
  input wire logic lvds_sel_in,
  input wire logic shift_in,
  input wire logic [sar_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sar_ctrl_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [sar_ctrl_pkg::DATA_W-1:0] rdata_out,
  output logic hold_out,
  output logic [sar_ctrl_pkg::CH_W-1:0] chan_sel_out,
  output logic [sar_ctrl_pkg::CODE_W-1:0] charge_redist_dac_out,
  output logic busy_out,
  output logic ready_out,
  output logic nap_out,
  output logic power_down_out,
  output logic [sar_ctrl_pkg::NUM_CH-1:0] sdo_out,
  output logic lvds_sdo_out,
  output logic serial_active_out
);
  import sar_ctrl_pkg::*;

  typedef struct packed {
    conv_state_t state;
    logic trig_prev;
    logic hold;
    logic [CH_W-1:0] chan;
    span_bank_t span_reg;
    span_bank_t span_snap;
    code_bank_t results;
    logic ready;
    logic overrun;
    logic nap_en;
    logic pdown;
    logic nap;
    logic [CH_W-1:0] lanes_m1;
    logic lvds_mode;
    logic sar_start;
    logic load_ser;
    logic busy;
    logic [DATA_W-1:0] rdata;
  } ctrl_st_t;

  ctrl_st_t st;
  ctrl_st_t next_st;
  reg_req_t req;
  logic trig_rise;
  logic [CH_W:0] first_en;
  logic [CH_W:0] next_en;
  code_t sar_result;
  logic sar_done;
  logic ser_active;
  logic ser_pending;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a zero span code switches the channel off
  function automatic logic span_enabled(input logic [SPAN_W-1:0] span);
    span_enabled = span != SPAN_DISABLED;
  endfunction

  function automatic logic is_bipolar(input logic [SPAN_W-1:0] span);
    case (span)
      3'h7, 3'h6, 3'h3, 3'h2: is_bipolar = 1'b1;
      3'h5, 3'h4, 3'h1: is_bipolar = 1'b0;
      default: is_bipolar = 1'b0;
    endcase
  endfunction

  // search result is offset binary; bipolar flips the msb
  function automatic code_t format_code(input code_t raw,
    input logic [SPAN_W-1:0] span);
    format_code = raw;
    if (!span_enabled(span))
      format_code = '0;
    else if (is_bipolar(span))
      format_code[CODE_W-1] = ~raw[CODE_W-1];
  endfunction

  // lowest enabled channel at or above from; top bit set when none
  function automatic logic [CH_W:0] find_enabled(input span_bank_t spans,
    input logic [CH_W:0] from);
    find_enabled = (CH_W+1)'(NUM_CH);
    for (int c = NUM_CH - 1; c >= 0; c--)
    begin
      if ((CH_W+1)'(c) >= from && span_enabled(spans[c]))
        find_enabled = (CH_W+1)'(c);
    end
  endfunction

  // ----------------------------------------------------------------
  // register words
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] ctrl_word(input logic nap_en,
    input logic pdown, input logic [CH_W-1:0] lanes_m1);
    ctrl_word = '0;
    ctrl_word[CTRL_NAP_BIT] = nap_en;
    ctrl_word[CTRL_PDOWN_BIT] = pdown;
    ctrl_word[CTRL_LANES_LSB +: CH_W] = lanes_m1;
  endfunction

  function automatic logic [DATA_W-1:0] status_word(input logic busy,
    input logic ready, input logic overrun, input logic lvds);
    status_word = '0;
    status_word[STAT_BUSY_BIT] = busy;
    status_word[STAT_READY_BIT] = ready;
    status_word[STAT_OVERRUN_BIT] = overrun;
    status_word[STAT_LVDS_BIT] = lvds;
  endfunction

  // ----------------------------------------------------------------
  // conversion engine and serial output
  // ----------------------------------------------------------------
  sar_engine #(
    .WIDTH(CODE_W)
  ) u_sar (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .start_in(st.sar_start),
    .comp_in(comp_in),
    .dac_code_out(charge_redist_dac_out),
    .result_out(sar_result),
    .done_out(sar_done)
  );

  result_serializer u_ser (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(st.load_ser),
    .codes_in(st.results),
    .lanes_m1_in(st.lanes_m1),
    .lvds_mode_in(st.lvds_mode),
    .shift_in(shift_in),
    .lane_out(sdo_out),
    .lvds_out(lvds_sdo_out),
    .active_out(ser_active)
  );

  assign serial_active_out = ser_active;

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    req.wr = wr_in;
    req.rd = rd_in;
    req.addr = addr_in;
    req.wdata = wdata_in;
    trig_rise = conversion_trigger_in & ~st.trig_prev;
    first_en = find_enabled(st.span_reg, '0);
    next_en = find_enabled(st.span_snap, (CH_W+1)'(st.chan) + 1'b1);
    next_st.trig_prev = conversion_trigger_in;
    next_st.sar_start = 1'b0;
    next_st.load_ser = 1'b0;
    next_st.rdata = '0;

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    if (req.wr)
    begin
      case (req.addr)
        REG_SPAN: next_st.span_reg = req.wdata[NUM_CH*SPAN_W-1:0];
        REG_CTRL:
        begin
          next_st.nap_en = req.wdata[CTRL_NAP_BIT];
          next_st.pdown = req.wdata[CTRL_PDOWN_BIT];
          next_st.lanes_m1 = req.wdata[CTRL_LANES_LSB +: CH_W];
        end
        REG_STATUS:
        begin
          if (req.wdata[STAT_OVERRUN_BIT])
            next_st.overrun = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // --------------------------------------------------------------
    // register reads, data in the following cycle
    // --------------------------------------------------------------
    if (req.rd)
    begin
      case (req.addr)
        REG_SPAN: next_st.rdata = DATA_W'(st.span_reg);
        REG_CTRL:
          next_st.rdata = ctrl_word(st.nap_en, st.pdown, st.lanes_m1);
        REG_STATUS:
          next_st.rdata = status_word(st.busy, st.ready, st.overrun,
            st.lvds_mode);
        default:
        begin
          if (req.addr >= REG_RESULT_BASE)
            next_st.rdata = DATA_W'(st.results[CH_W'(req.addr -
              REG_RESULT_BASE)]);
        end
      endcase
    end

    // --------------------------------------------------------------
    // conversion sequence
    // --------------------------------------------------------------
    case (st.state)
      CONV_IDLE:
      begin
        if (trig_rise && !st.pdown)
        begin
          next_st.hold = 1'b1;
          next_st.span_snap = st.span_reg;
          next_st.ready = 1'b0;
          next_st.results = '0;
          if (first_en[CH_W])
            next_st.state = CONV_FINISH;
          else
          begin
            next_st.chan = first_en[CH_W-1:0];
            next_st.sar_start = 1'b1;
            next_st.state = CONV_RUN;
          end
        end
      end
      CONV_RUN:
      begin
        if (sar_done)
        begin
          next_st.results[st.chan] = format_code(sar_result,
            st.span_snap[st.chan]);
          if (next_en[CH_W])
            next_st.state = CONV_FINISH;
          else
          begin
            next_st.chan = next_en[CH_W-1:0];
            next_st.sar_start = 1'b1;
          end
        end
      end
      CONV_FINISH:
      begin
        next_st.hold = 1'b0;
        next_st.ready = 1'b1;
        next_st.load_ser = 1'b1;
        next_st.state = CONV_IDLE;
      end
      default:
        next_st.state = CONV_IDLE;
    endcase

    // a trigger while converting is dropped and flagged; set beats clear
    if (trig_rise && st.state != CONV_IDLE)
      next_st.overrun = 1'b1;

    // --------------------------------------------------------------
    // busy and nap flags
    // --------------------------------------------------------------
    next_st.busy = next_st.state != CONV_IDLE;
    // a frame about to load counts as pending, or nap would overlap it
    ser_pending = ser_active || st.load_ser;
    // nap only between conversions, with nothing left to shift out
    next_st.nap = st.nap_en && next_st.state == CONV_IDLE &&
      !next_st.hold && !ser_pending;

    // --------------------------------------------------------------
    // reset overrides everything above
    // --------------------------------------------------------------
    if (sys_rst_in)
    begin
      next_st = '0;
      next_st.state = CONV_IDLE;
      next_st.lanes_m1 = LANES_M1_RESET;
      next_st.trig_prev = 1'b1;
      next_st.lvds_mode = lvds_sel_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_out = st.rdata;
  assign hold_out = st.hold;
  assign chan_sel_out = st.chan;
  assign busy_out = st.busy;
  assign ready_out = st.ready;
  assign nap_out = st.nap;
  assign power_down_out = st.pdown;
endmodule

// ---- sar_ctrl_pkg.sv ----
// Function
// - the device alternates between tracking all inputs and converting.
// - a rising conversion trigger holds all channels at once and starts.
// - held channels share one 18-bit charge_redist_dac one at a time.
// - each channel runs a binary search from half scale down to 1/262144.
// - results become ready for transfer only after all channels finish.
// - each result has two to the power 18 distinct codes.
// - each channel has its own 3-bit span code, changeable per conversion.
// - bipolar spans give two's complement, unipolar spans straight binary.
// - span codes 7, 6, 3 and 2 are bipolar.
// - span codes 5, 4 and 1 are unipolar.
// - disabled channels are skipped so the others convert sooner.
// - a strap pin selects CMOS or LVDS serial output.
// - in CMOS mode one to eight output lanes may be used.
// - eight channels convert at 200ksps per channel; here eight channels take 161 clocks from trigger to ready, 16.1us at 100ns.
// - nap and power-down modes cut power while inactive.
package sar_ctrl_pkg;
  localparam int CODE_W = 18;
  localparam int NUM_CH = 8;
  localparam int SPAN_W = 3;
  localparam int CH_W = 3;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  typedef logic [CODE_W-1:0] code_t;
  typedef code_t [NUM_CH-1:0] code_bank_t;
  typedef logic [NUM_CH-1:0][SPAN_W-1:0] span_bank_t;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_SPAN = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_RESULT_BASE = 4'h8;
  localparam int CTRL_NAP_BIT = 0;
  localparam int CTRL_PDOWN_BIT = 1;
  localparam int CTRL_LANES_LSB = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_OVERRUN_BIT = 2;
  localparam int STAT_LVDS_BIT = 3;
  localparam logic [SPAN_W-1:0] SPAN_DISABLED = 3'h0;
  localparam logic [CH_W-1:0] LANES_M1_RESET = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAMPLE_RATE_SPS = 200000;
  localparam int SAMPLE_PERIOD_NS = 1000000000 / SAMPLE_RATE_SPS;
  localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_FINISH = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;
endpackage

// ---- sar_engine.sv ----
`timescale 1ns/100ps
module sar_engine
  import sar_ctrl_pkg::*;
#(
  parameter int WIDTH = CODE_W
)(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic comp_in,
  output logic [WIDTH-1:0] dac_code_out,
  output logic [WIDTH-1:0] result_out,
  output logic done_out
);
  typedef struct packed {
    logic busy;
    logic [$clog2(WIDTH)-1:0] idx;
    logic [WIDTH-1:0] code;
    logic [WIDTH-1:0] result;
    logic done;
  } sar_st_t;

  sar_st_t st;
  sar_st_t next_st;

  // ----------------------------------------------------------------
  // one trial bit per clock, msb first
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (sys_rst_in)
    begin
      next_st = '0;
    end
    else if (start_in)
    begin
      next_st.busy = 1'b1;
      next_st.idx = $clog2(WIDTH)'(WIDTH - 1);
      next_st.code = '0;
      next_st.code[WIDTH-1] = 1'b1;
    end
    else if (st.busy)
    begin
      // comparator low means the trial weight overshoots the input
      if (!comp_in)
        next_st.code[st.idx] = 1'b0;
      if (st.idx == '0)
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        next_st.result = comp_in ? st.code : (st.code & ~WIDTH'(1));
      end
      else
      begin
        next_st.idx = st.idx - 1'b1;
        next_st.code[st.idx - 1'b1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    st <= next_st;
  end

  assign dac_code_out = st.code;
  assign result_out = st.result;
  assign done_out = st.done;
endmodule

// ---- result_serializer.sv ----
`timescale 1ns/100ps
module result_serializer
  import sar_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic load_in,
  input wire sar_ctrl_pkg::code_bank_t codes_in,
  input wire logic [CH_W-1:0] lanes_m1_in,
  input wire logic lvds_mode_in,
  input wire logic shift_in,
  output logic [NUM_CH-1:0] lane_out,
  output logic lvds_out,
  output logic active_out
);
  typedef struct packed {
    logic active;
    logic [4:0] bit_pos;
    logic [CH_W:0] slot;
    logic [NUM_CH-1:0] lanes;
    logic lvds;
  } ser_st_t;

  ser_st_t st;
  ser_st_t next_st;
  logic [CH_W:0] lane_cnt;
  logic [NUM_CH-1:0] lane_bits;

  // channel carried by a lane in a given word slot
  function automatic logic [CH_W+3:0] lane_chan(input logic [CH_W:0] lane,
    input logic [CH_W:0] slot, input logic [CH_W:0] cnt);
    lane_chan = (CH_W+4)'(lane) + (CH_W+4)'(slot) * (CH_W+4)'(cnt);
  endfunction

  // ----------------------------------------------------------------
  // lane k sends channels k, k+n, k+2n ... msb first
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    lane_cnt = lvds_mode_in ? (CH_W+1)'(1) : ((CH_W+1)'(lanes_m1_in) + 1'b1);
    if (sys_rst_in)
      next_st = '0;
    else if (load_in)
    begin
      next_st.active = 1'b1;
      next_st.bit_pos = '0;
      next_st.slot = '0;
    end
    else if (st.active && shift_in)
    begin
      if (st.bit_pos == 5'(CODE_W - 1))
      begin
        next_st.bit_pos = '0;
        next_st.slot = st.slot + 1'b1;
        if (lane_chan('0, st.slot + 1'b1, lane_cnt) >= (CH_W+4)'(NUM_CH))
          next_st.active = 1'b0;
      end
      else
        next_st.bit_pos = st.bit_pos + 1'b1;
    end
    for (int l = 0; l < NUM_CH; l++)
    begin
      lane_bits[l] = 1'b0;
      if (next_st.active && (CH_W+1)'(l) < lane_cnt &&
          lane_chan((CH_W+1)'(l), next_st.slot, lane_cnt) <
          (CH_W+4)'(NUM_CH))
        lane_bits[l] = codes_in[lane_chan((CH_W+1)'(l), next_st.slot,
          lane_cnt)][5'(CODE_W - 1) - next_st.bit_pos];
    end
    next_st.lanes = lvds_mode_in ? '0 : lane_bits;
    next_st.lvds = lvds_mode_in & lane_bits[0];
  end

  always_ff @(posedge clk_in)
  begin
    st <= next_st;
  end

  assign lane_out = st.lanes;
  assign lvds_out = st.lvds;
  assign active_out = st.active;
endmodule

// ---- sar_ctrl_asserts.sv ----
`timescale 1ns/100ps
module sar_ctrl_asserts
  import sar_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic conversion_trigger_in,
  input wire logic rd_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic hold_out,
  input wire logic [CODE_W-1:0] charge_redist_dac_out,
  input wire logic busy_out,
  input wire logic ready_out,
  input wire logic nap_out,
  input wire logic power_down_out,
  input wire logic [NUM_CH-1:0] sdo_out,
  input wire logic lvds_sdo_out,
  input wire logic serial_active_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_TRIG_HOLD: assert property (
    conversion_trigger_in && !$past(conversion_trigger_in) &&
    !$past(sys_rst_in) && !busy_out && !power_down_out
    |=> hold_out && busy_out) else $error("trigger did not start hold");
  AST_HOLD_BUSY: assert property (
    hold_out |-> busy_out) else $error("hold outside conversion");
  AST_READY_END: assert property (
    $rose(ready_out) |-> !hold_out && !busy_out)
    else $error("ready before conversion end");
  AST_CONV_BOUND: assert property (
    $rose(hold_out) |-> ##[21:161] $rose(ready_out))
    else $error("conversion length out of bounds");
  AST_DAC_FIRST: assert property (
    $rose(hold_out) |=> charge_redist_dac_out == 18'h20000)
    else $error("search did not start at half scale");
  AST_PDOWN_BLOCK: assert property (
    power_down_out && !busy_out |=> !busy_out)
    else $error("conversion started in power down");
  AST_NAP_IDLE: assert property (
    nap_out |-> !hold_out && !serial_active_out)
    else $error("nap while active");
  AST_LANES_QUIET: assert property (
    !serial_active_out |-> sdo_out == 8'h0 && !lvds_sdo_out)
    else $error("lanes active outside frame");
  AST_LVDS_ONLY: assert property (
    lvds_sdo_out |-> sdo_out == 8'h0) else $error("both link modes drive");
  AST_RDATA_IDLE: assert property (
    !$past(rd_in) |-> rdata_out == 32'h0) else $error("read data unasked");

  COV_CONV: cover property ($rose(ready_out));
  COV_RETRIG: cover property (busy_out && $rose(conversion_trigger_in));
  COV_FRAME: cover property ($fell(serial_active_out));
endmodule

bind sar_conv_ctrl sar_ctrl_asserts chk(.clk_in, .sys_rst_in,
  .conversion_trigger_in, .rd_in, .rdata_out, .hold_out,
  .charge_redist_dac_out, .busy_out, .ready_out, .nap_out,
  .power_down_out, .sdo_out, .lvds_sdo_out, .serial_active_out);

// ---- analog_front.sv ----
`timescale 1ns/100ps
module analog_front
  import sar_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic hold_in,
  input wire logic [CH_W-1:0] chan_sel_in,
  input wire logic [CODE_W-1:0] dac_in,
  input wire sar_ctrl_pkg::code_bank_t level_in,
  output logic comp_out
);
  code_bank_t held = '0;

  // track while not holding, freeze all channels together
  always @(posedge clk_in)
    if (!hold_in)
      held <= level_in;

  // one comparator against the shared dac, per selected channel
  assign comp_out = held[chan_sel_in] >= dac_in;
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
  import sar_ctrl_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic conversion_trigger_in = 1'b0;
  logic lvds_sel_in = 1'b0;
  logic shift_in = 1'b0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0;
  logic comp_in;
  logic [DATA_W-1:0] rdata_out;
  logic hold_out, busy_out, ready_out, nap_out, power_down_out;
  logic lvds_sdo_out, serial_active_out;
  logic [CH_W-1:0] chan_sel_out;
  logic [CODE_W-1:0] charge_redist_dac_out;
  logic [NUM_CH-1:0] sdo_out;
  code_bank_t level = '0;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 92835;

  sar_conv_ctrl DUT(.clk_in, .sys_rst_in, .conversion_trigger_in, .comp_in,
    .lvds_sel_in, .shift_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .hold_out, .chan_sel_out, .charge_redist_dac_out,
    .busy_out, .ready_out, .nap_out, .power_down_out, .sdo_out,
    .lvds_sdo_out, .serial_active_out);
  analog_front model(.clk_in, .hold_in(hold_out), .chan_sel_in(chan_sel_out),
    .dac_in(charge_redist_dac_out), .level_in(level), .comp_out(comp_in));

  always #50 clk_in = ~clk_in;

  function automatic code_t expect_code(input logic [2:0] sp, input code_t v);
    case (sp)
      3'h0: return '0;
      3'h7, 3'h6, 3'h3, 3'h2: return v ^ 18'h20000;
      default: return v;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    check(what, rdata_out, exp);
  endtask

  task automatic do_reset(input logic lv);
    sys_rst_in <= 1'b1;
    lvds_sel_in <= lv;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
  endtask

  task automatic pulse_trig;
    @(posedge clk_in);
    conversion_trigger_in <= 1'b1;
    @(posedge clk_in);
    conversion_trigger_in <= 1'b0;
  endtask

  task automatic run_conv(input int i, input logic lv);
    span_bank_t sp;
    code_t r [NUM_CH];
    int n, k, s, ch, w;
    n = (lv || i == 1) ? 1 : (i == 0 ? 8 : 1 + ($random(seed) & 7));
    for (ch = 0; ch < NUM_CH; ch++)
    begin
      sp[ch] = i[0] ? SPAN_W'($random(seed)) : SPAN_W'(ch + i);
      r[ch] = CODE_W'($random(seed));
      level[ch] <= r[ch];
    end
    if (sp == '0)
      sp[0] = 3'h7;
    for (ch = 0; ch < NUM_CH; ch++)
      r[ch] = expect_code(sp[ch], r[ch]);
    wr(REG_SPAN, DATA_W'(sp));
    wr(REG_CTRL, DATA_W'(n - 1) << CTRL_LANES_LSB);
    rd_chk("span", REG_SPAN, DATA_W'(sp));
    pulse_trig();
    repeat (2) @(posedge clk_in);
    // a second rise while busy must be refused and flagged
    pulse_trig();
    for (w = 0; w < 400 && ready_out !== 1'b1; w++)
      @(negedge clk_in);
    check("hold", hold_out, 0);
    rd_chk("status", REG_STATUS, DATA_W'({lv, 3'b110}));
    wr(REG_STATUS, 32'h4);
    rd_chk("overrun", REG_STATUS, DATA_W'({lv, 3'b010}));
    for (ch = 0; ch < NUM_CH; ch++)
      rd_chk("result", REG_RESULT_BASE + ADDR_W'(ch), DATA_W'(r[ch]));
    for (s = 0; s < (NUM_CH + n - 1) / n * CODE_W; s++)
    begin
      @(negedge clk_in);
      for (k = 0; k < n; k++)
      begin
        ch = k + (s / CODE_W) * n;
        if (ch < NUM_CH)
          check("lane", lv ? lvds_sdo_out : sdo_out[k],
            r[ch][CODE_W - 1 - s % CODE_W]);
      end
      @(posedge clk_in);
      shift_in <= 1'b1;
      @(posedge clk_in);
      shift_in <= 1'b0;
    end
    @(negedge clk_in);
    check("frame end", serial_active_out, 0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    do_reset(1'b0);
    @(posedge clk_in);
    rd_chk("status", REG_STATUS, 32'h0);
    rd_chk("unmapped", 4'h5, 32'h0);
    for (int i = 0; i < 6; i++)
      run_conv(i, 1'b0);
    wr(REG_CTRL, 32'h2);
    pulse_trig();
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    check("pdown busy", busy_out, 0);
    check("pdown", power_down_out, 1);
    wr(REG_CTRL, 32'h1);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check("nap", nap_out, 1);
    wr(REG_CTRL, 32'h0);
    do_reset(1'b1);
    @(posedge clk_in);
    run_conv(0, 1'b1);
    print_verdict();
  end

  initial
  begin
    #(30000 * 100);
    n_fail++;
    print_verdict();
  end
endmodule
